// ### sti_consts.svh
// Constants for the card level translator control block.
// Assumes a 250 MHz core clock; all counts derive from its period.
`ifndef STI_CONSTS_SVH
`define STI_CONSTS_SVH

// Clock period and derived cycle counts (least times round up)
`define STI_CLK_NS      4
`define STI_ONESHOT_NS  20
`define STI_ONESHOT_CYC ((`STI_ONESHOT_NS + `STI_CLK_NS - 1) / `STI_CLK_NS)
`define STI_COMMIT_NS   40
`define STI_COMMIT_CYC  ((`STI_COMMIT_NS + `STI_CLK_NS - 1) / `STI_CLK_NS)

// Factory address variants
`define STI_ADDR_A      7'h60
`define STI_ADDR_B      7'h61
`define STI_ADDR_C      7'h62

// Configuration register: pointer, reset value, field positions
`define STI_REG_PTR     8'h00
`define STI_CFG_RST     8'h00
// Pin synchroniser reset: bus and data lines idle high, rest low
`define STI_SYNC_RST    7'h66
`define STI_CFG_OFF_BIT 7
`define STI_CFG_RSV_BIT 2
`define STI_CFG_V3_BIT  1
`define STI_RW_BIT      0
`define STI_BYTE_BITS   4'h8

`endif

// ### sti_pkg.sv
// Types shared by the translator control block files.
// Assumes sti_consts.svh supplies the numeric constants.
package sti_pkg;

	// Serial slave sequencer states
	typedef enum logic [3:0] {
		I2C_IDLE   = 4'h0,
		I2C_ADDR   = 4'h1,
		I2C_AACK   = 4'h2,
		I2C_WDATA  = 4'h3,
		I2C_WACK   = 4'h4,
		I2C_RDATA  = 4'h5,
		I2C_RACK   = 4'h6,
		I2C_HOLD   = 4'h7,
		I2C_COMMIT = 4'h8
	} sti_i2c_e;

	// Data channel ownership states
	typedef enum logic [2:0] {
		ARB_IDLE  = 3'h0,
		ARB_HOST  = 3'h1,
		ARB_CARD  = 3'h2,
		ARB_KICKC = 3'h3,
		ARB_KICKH = 3'h4
	} sti_arb_e;

	typedef logic [7:0] sti_byte_t;

endpackage : sti_pkg

// ### sti_data_arb.sv
// Direction arbiter of the two-way card data channel.
// Assumes both line inputs are already synchronised to core_clk_i.
`include "sti_consts.svh"

module sti_data_arb #(
	parameter int ONESHOT_CYC = `STI_ONESHOT_CYC
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic             host_in_i,
	input  wire logic             card_in_i,
	output logic                  host_io_o,
	output logic                  host_io_oe_o,
	output logic                  card_io_o,
	output logic                  card_io_oe_o,
	output sti_pkg::sti_arb_e     owner_o
);
	import sti_pkg::*;

	// Kick must outlast the two-flop lag so idle sees the line high
	if (ONESHOT_CYC < 3 || ONESHOT_CYC > 255) begin : g_bad_oneshot
		$error("one-shot length out of range");
	end

	sti_arb_e   state_ff;
	sti_arb_e   nxt_state;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;

	localparam logic [7:0] KICK_LAST = 8'(ONESHOT_CYC - 1);

	// First low side wins; release hands over to a one-shot kick
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		unique case (state_ff)
			ARB_IDLE: begin
				if (!host_in_i) nxt_state = ARB_HOST;
				else if (!card_in_i) nxt_state = ARB_CARD;
			end
			ARB_HOST: begin
				if (host_in_i) begin
					nxt_state = ARB_KICKC;
					nxt_cnt = KICK_LAST;
				end
			end
			ARB_CARD: begin
				if (card_in_i) begin
					nxt_state = ARB_KICKH;
					nxt_cnt = KICK_LAST;
				end
			end
			ARB_KICKC, ARB_KICKH: begin
				if (cnt_ff == 8'h00) nxt_state = ARB_IDLE;
				else nxt_cnt = cnt_ff - 8'h01;
			end
			default: nxt_state = ARB_IDLE;
		endcase
	end

	// State and line drives registered together, so they never skew
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= ARB_IDLE;
			cnt_ff <= 8'h00;
			host_io_oe_o <= 1'b0;
			card_io_oe_o <= 1'b0;
			host_io_o <= 1'b1;
			card_io_o <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			card_io_oe_o <= (nxt_state == ARB_HOST) || (nxt_state == ARB_KICKC);
			card_io_o <= (nxt_state == ARB_KICKC);
			host_io_oe_o <= (nxt_state == ARB_CARD) || (nxt_state == ARB_KICKH);
			host_io_o <= (nxt_state == ARB_KICKH);
		end
	end

	assign owner_o = state_ff;

	follow_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == ARB_IDLE && !host_in_i) |=> (card_io_oe_o && !card_io_o))
		else $error("card side not following host low");

	kick_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == ARB_HOST && host_in_i) |=> (card_io_oe_o && card_io_o) [*5]
		##1 !card_io_oe_o)
		else $error("card kick length wrong");

	no_lockup_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == ARB_CARD && card_in_i) |=> !(host_io_oe_o && !host_io_o))
		else $error("host side still held low after release");

endmodule // sti_data_arb

// ### sti_ctrl.sv
// Control logic of the card level translator: serial slave,
// configuration byte, regulator control and signal paths.
// Assumes rst_i is the supply-driven power-on reset; all pins async.
//
// Function
// - Regulate card rail at 1.8 or 3 V.
// - Reset selects 1.8 V until host writes.
// - Regulator off keeps all translation paths working.
// - Protection trip switches regulator output off.
// - First falling side owns data; other follows.
// - Rising edge: pulse non-driving side high briefly.
// - Both driving: each returns high when released; code drives the side released first low until the other side releases.
// - Reset and clock paths: host to card only.
// - Power-on reset sets register and sequencer defaults.
// - Later reset only when host supply below 1.2V.
// - Serial bus up to 100 or 400 kHz.
// - Whole bytes, most significant bit first.
// - Address byte: seven bits plus direction bit.
// - Slave address fixed per variant: 60h/61h/62h.
// - Pointer always 00h; no subaddress byte.
// - Read returns one data byte.
// - Acknowledge or not-acknowledge after read both accepted.
// - Slave acknowledges address and write data byte on ninth clock.
// - Only STOP commits received byte to register.
// - Requests ignored while commit in progress.
// - Read address acknowledged, then byte sent.
// - Bit 1 selects level: 0 1.8V, 1 3V.
// - Bit 7 set turns regulator off.
`include "sti_consts.svh"

module sti_ctrl #(
	parameter logic [6:0] SLAVE_ADDR = `STI_ADDR_A,
	parameter int         COMMIT_CYC = `STI_COMMIT_CYC,
	parameter int         ONESHOT_CYC = `STI_ONESHOT_CYC
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	input  wire logic             host_rst_i,
	input  wire logic             host_clk_i,
	input  wire logic             host_io_i,
	output logic                  host_io_o,
	output logic                  host_io_oe_o,
	input  wire logic             card_io_i,
	output logic                  card_io_o,
	output logic                  card_io_oe_o,
	output logic                  card_reset_path_o,
	output logic                  card_clock_path_o,
	input  wire logic             therm_trip_i,
	input  wire logic             ovc_trip_i,
	output logic                  ldo_en_o,
	output logic                  ldo_vsel_3v_o,
	output sti_pkg::sti_byte_t    cfg_o
);
	import sti_pkg::*;

	// Only the three factory addresses exist
	if (SLAVE_ADDR != `STI_ADDR_A && SLAVE_ADDR != `STI_ADDR_B
		&& SLAVE_ADDR != `STI_ADDR_C) begin : g_bad_addr
		$error("slave address is not a factory variant");
	end
	if (COMMIT_CYC < 1 || COMMIT_CYC > 255) begin : g_bad_commit
		$error("commit length out of range");
	end

	localparam logic [7:0] COMMIT_LAST = 8'(COMMIT_CYC - 1);
	localparam sti_byte_t  RSV_MASK = sti_byte_t'(1) << `STI_CFG_RSV_BIT;

	// Pin synchroniser stages: scl, sda, rst, clk, io, card io, trip
	logic [6:0] meta_ff;
	logic [6:0] sync_ff;
	logic [1:0] bus_d_ff;
	logic       scl_s;
	logic       sda_s;
	logic       host_rst_s;
	logic       host_clk_s;
	logic       host_io_s;
	logic       card_io_s;
	logic       trip_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_w;
	logic       stop_w;

	// Sequencer and register state
	sti_i2c_e   state_ff;
	logic [3:0] cnt_ff;
	sti_byte_t  sh_ff;
	sti_byte_t  wbyte_ff;
	sti_byte_t  cfg_ff;
	logic       pend_ff;
	logic       oe_ff;
	logic [7:0] cmt_ff;
	logic       commit_w;

	// Two flops per pin; second stage is the first one logic may see
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Idle levels, so no false edge or trip follows reset
			meta_ff <= `STI_SYNC_RST;
			sync_ff <= `STI_SYNC_RST;
		end else begin
			meta_ff <= {scl_i, sda_i, host_rst_i, host_clk_i,
				host_io_i, card_io_i, therm_trip_i | ovc_trip_i};
			sync_ff <= meta_ff;
		end
	end

	assign scl_s = sync_ff[6];
	assign sda_s = sync_ff[5];
	assign host_rst_s = sync_ff[4];
	assign host_clk_s = sync_ff[3];
	assign host_io_s = sync_ff[2];
	assign card_io_s = sync_ff[1];
	assign trip_s = sync_ff[0];

	// Delayed copy of the bus for edge and condition detection
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_d_ff <= 2'h3;
		end else begin
			bus_d_ff <= {scl_s, sda_s};
		end
	end

	// Edges and conditions, taken from synchronised levels only
	assign scl_rise = scl_s & ~bus_d_ff[1];
	assign scl_fall = ~scl_s & bus_d_ff[1];
	assign start_w = scl_s & bus_d_ff[1] & ~sda_s & bus_d_ff[0];
	assign stop_w = scl_s & bus_d_ff[1] & sda_s & ~bus_d_ff[0];
	assign commit_w = (state_ff == I2C_COMMIT) && (cmt_ff == 8'h00);

	// Byte sequencer: address, one data byte, then wait for STOP
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= I2C_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			wbyte_ff <= 8'h00;
			pend_ff <= 1'b0;
			oe_ff <= 1'b0;
			cmt_ff <= 8'h00;
		end else if (start_w && state_ff != I2C_COMMIT) begin
			state_ff <= I2C_ADDR;
			cnt_ff <= 4'h0;
			oe_ff <= 1'b0;
			pend_ff <= 1'b0; // Repeated start drops the byte
		end else if (stop_w && state_ff != I2C_COMMIT) begin
			oe_ff <= 1'b0;
			pend_ff <= 1'b0;
			if (state_ff == I2C_HOLD && pend_ff) begin
				state_ff <= I2C_COMMIT;
				cmt_ff <= COMMIT_LAST;
			end else begin
				state_ff <= I2C_IDLE;
			end
		end else begin
			unique case (state_ff)
				I2C_IDLE, I2C_HOLD: begin
					oe_ff <= 1'b0; // Wait for next condition
				end
				I2C_ADDR: begin
					if (scl_rise) begin
						sh_ff <= {sh_ff[6:0], sda_s};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == `STI_BYTE_BITS) begin
						if (sh_ff[7:1] == SLAVE_ADDR) begin
							oe_ff <= 1'b1;
							state_ff <= I2C_AACK;
						end else begin
							state_ff <= I2C_IDLE;
						end
					end
				end
				I2C_AACK: begin
					if (scl_fall) begin
						cnt_ff <= 4'h0;
						if (sh_ff[`STI_RW_BIT]) begin
							sh_ff <= cfg_ff;
							oe_ff <= ~cfg_ff[7];
							state_ff <= I2C_RDATA;
						end else begin
							oe_ff <= 1'b0;
							state_ff <= I2C_WDATA;
						end
					end
				end
				I2C_WDATA: begin
					if (scl_rise) begin
						sh_ff <= {sh_ff[6:0], sda_s};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == `STI_BYTE_BITS) begin
						oe_ff <= 1'b1;
						wbyte_ff <= sh_ff;
						state_ff <= I2C_WACK;
					end
				end
				I2C_WACK: begin
					if (scl_fall) begin
						oe_ff <= 1'b0;
						pend_ff <= 1'b1;
						state_ff <= I2C_HOLD;
					end
				end
				I2C_RDATA: begin
					if (scl_fall) begin
						if (cnt_ff == 4'h7) begin
							oe_ff <= 1'b0;
							state_ff <= I2C_RACK;
						end else begin
							cnt_ff <= cnt_ff + 4'h1;
							sh_ff <= {sh_ff[6:0], 1'b0};
							oe_ff <= ~sh_ff[6];
						end
					end
				end
				I2C_RACK: begin
					if (scl_rise) begin
						state_ff <= I2C_HOLD;
					end
				end
				I2C_COMMIT: begin
					if (cmt_ff == 8'h00) state_ff <= I2C_IDLE;
					else cmt_ff <= cmt_ff - 8'h01;
				end
				default: state_ff <= I2C_IDLE;
			endcase
		end
	end

	// Configuration byte; reserved bit never stores
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_ff <= `STI_CFG_RST;
		end else if (commit_w) begin
			cfg_ff <= wbyte_ff & ~RSV_MASK;
		end
	end

	// Regulator control; a trip overrides software until it clears
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ldo_en_o <= 1'b1;
			ldo_vsel_3v_o <= 1'b0;
		end else begin
			ldo_en_o <= ~cfg_ff[`STI_CFG_OFF_BIT] & ~trip_s;
			ldo_vsel_3v_o <= cfg_ff[`STI_CFG_V3_BIT];
		end
	end

	// One-way paths; they never look at the regulator state
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			card_reset_path_o <= 1'b0;
			card_clock_path_o <= 1'b0;
		end else begin
			card_reset_path_o <= host_rst_s;
			card_clock_path_o <= host_clk_s;
		end
	end

	// Open-drain: only the enable moves, the level is always low
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_ff;
	assign cfg_o = cfg_ff;

	sti_data_arb #(
		.ONESHOT_CYC (ONESHOT_CYC)
	) u_data_arb (
		.core_clk_i   (core_clk_i),
		.rst_i        (rst_i),
		.host_in_i    (host_io_s),
		.card_in_i    (card_io_s),
		.host_io_o    (host_io_o),
		.host_io_oe_o (host_io_oe_o),
		.card_io_o    (card_io_o),
		.card_io_oe_o (card_io_oe_o),
		.owner_o      ()
	);

	vsel_default_a: assert property (@(posedge core_clk_i)
		$past(rst_i) && !rst_i |-> (cfg_ff == `STI_CFG_RST) && !ldo_vsel_3v_o)
		else $error("regulator level not at default after reset");

	trip_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		trip_s |=> !ldo_en_o)
		else $error("regulator still on during protection trip");

	level_sel_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$changed(cfg_ff[`STI_CFG_V3_BIT]) |=> ldo_vsel_3v_o == $past(cfg_ff[1]))
		else $error("level select does not follow bit 1");

	off_paths_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cfg_ff[`STI_CFG_OFF_BIT] && $rose(host_clk_s) |=> !ldo_en_o && card_clock_path_o)
		else $error("regulator off or clock path stalled");

	rst_path_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(host_rst_s) |=> card_reset_path_o ##1 card_reset_path_o == host_rst_s
		|| $changed(host_rst_s))
		else $error("card reset path not following host");

	addr_ack_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == I2C_ADDR && scl_fall && cnt_ff == `STI_BYTE_BITS
		&& !start_w && !stop_w) |=> sda_oe_o == ($past(sh_ff[7:1]) == SLAVE_ADDR))
		else $error("address acknowledge does not match address");

	commit_only_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$changed(cfg_ff) |-> $past(state_ff) == I2C_COMMIT)
		else $error("register changed outside a commit");

	busy_ignore_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == I2C_COMMIT && (start_w || stop_w)) |=>
		(state_ff == I2C_COMMIT || state_ff == I2C_IDLE) && !sda_oe_o)
		else $error("request taken during commit");

	read_first_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == I2C_AACK && scl_fall && sh_ff[0] && !start_w && !stop_w)
		|=> state_ff == I2C_RDATA && sda_oe_o == !cfg_ff[7])
		else $error("read data first bit wrong");

	write_ack_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		state_ff == I2C_WACK |-> sda_oe_o && !sda_o)
		else $error("data byte not acknowledged");

	read_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == I2C_RDATA && scl_fall && cnt_ff == 4'h7 && !start_w && !stop_w)
		|=> state_ff == I2C_RACK && !sda_oe_o)
		else $error("data line not released after read byte");

	wrong_addr_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == I2C_ADDR && scl_fall && cnt_ff == `STI_BYTE_BITS
		&& sh_ff[7:1] != SLAVE_ADDR && !start_w && !stop_w)
		|=> state_ff == I2C_IDLE && !sda_oe_o)
		else $error("foreign address answered");

	commit_delay_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_ff == I2C_HOLD && pend_ff && stop_w) |-> ##10 commit_w)
		else $error("received byte not committed after stop");

endmodule // sti_ctrl

// ### sti_i2c_master.sv
// Serial bus master model driving the block's clock and data pins.
// Assumes the bench resolves SDA as open drain with a pull-up.
module sti_i2c_master (
	input  wire logic core_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Half of a 64 ns link clock period at 4 ns per core cycle
	localparam int HALF = 8;

	// Bus idle: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic half_wait();
		repeat (HALF) @(posedge core_clk_i);
	endtask

	// Gap lets a caller start early to probe a busy slave
	task automatic start(input int gap);
		repeat (gap) @(posedge core_clk_i);
		sda_low_o <= 1'b1;
		half_wait();
		scl_o <= 1'b0;
		half_wait();
	endtask

	// Data moves two cycles after SCL fall so hold time is kept
	task automatic bit_io(input logic b, output logic r);
		repeat (2) @(posedge core_clk_i);
		sda_low_o <= ~b;
		half_wait();
		scl_o <= 1'b1;
		half_wait();
		r = sda_i;
		scl_o <= 1'b0;
	endtask

	// Byte then ninth bit; n9 high releases SDA for the slave's answer
	task automatic xfer(input logic [7:0] tx, input logic n9, output logic [7:0] rx,
			output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(n9, r);
		ack = ~r;
	endtask

	// Ends every transaction; one data byte at most precedes it
	task automatic stop();
		repeat (2) @(posedge core_clk_i);
		sda_low_o <= 1'b1;
		half_wait();
		scl_o <= 1'b1;
		half_wait();
		sda_low_o <= 1'b0;
	endtask
endmodule // sti_i2c_master

// ### sti_ctrl_tb.sv
// Self-checking bench for the translator control block.
// Assumes sti_pkg, sti_consts.svh and the master model are compiled.
`include "sti_consts.svh"
module sti_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sti_pkg::*;

	logic      clk, rst, hrst, hclk, host_low, card_low, therm, ovc;
	logic      sda_oe, sda_lvl, host_o, host_oe, card_o, card_oe, crst, cclk, en, v3;
	wire       scl, m_low, sda_w, host_w, card_w;
	sti_byte_t cfg, model;
	int        bad_count, samples_checked;

	// Open-drain wires with pull-ups
	assign sda_w = ~(m_low | (sda_oe & ~sda_lvl));
	assign host_w = ~(host_low | (host_oe & ~host_o));
	assign card_w = ~(card_low | (card_oe & ~card_o));

	always #2 clk = ~clk;

	sti_i2c_master sti_i2c_master_i (.core_clk_i(clk), .sda_i(sda_w), .scl_o(scl),
		.sda_low_o(m_low));

	sti_ctrl #(.SLAVE_ADDR(`STI_ADDR_A)) sti_ctrl_i (.core_clk_i(clk), .rst_i(rst),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe), .host_rst_i(hrst),
		.host_clk_i(hclk), .host_io_i(host_w), .host_io_o(host_o), .host_io_oe_o(host_oe),
		.card_io_i(card_w), .card_io_o(card_o), .card_io_oe_o(card_oe),
		.card_reset_path_o(crst), .card_clock_path_o(cclk), .therm_trip_i(therm),
		.ovc_trip_i(ovc), .ldo_en_o(en), .ldo_vsel_3v_o(v3), .cfg_o(cfg));

	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_byte(input sti_byte_t got, input sti_byte_t exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Register and regulator outputs against the expected byte
	task automatic chk_cfg();
		chk_byte(cfg, model, "config");
		chk_bit(v3, model[1], "level select");
		chk_bit(en, ~model[7], "regulator on");
	endtask

	task automatic wr(input logic [6:0] a, input sti_byte_t d, input logic exp_ack);
		logic [7:0] rx;
		logic       ak;
		sti_i2c_master_i.start(16);
		sti_i2c_master_i.xfer({a, 1'b0}, 1'b1, rx, ak);
		chk_bit(ak, exp_ack, "write address ack");
		sti_i2c_master_i.xfer(d, 1'b1, rx, ak);
		chk_bit(ak, exp_ack, "data ack");
		chk_byte(cfg, model, "config before stop");
		sti_i2c_master_i.stop();
		repeat (20) @(posedge clk);
		if (exp_ack)
			model = d & 8'hfb; // Reserved bit reads zero
		chk_cfg();
	endtask

	task automatic rd(input logic [6:0] a, input logic n9, input logic exp_ack);
		logic [7:0] rx;
		logic       ak;
		sti_i2c_master_i.start(16);
		sti_i2c_master_i.xfer({a, 1'b1}, 1'b1, rx, ak);
		chk_bit(ak, exp_ack, "read address ack");
		sti_i2c_master_i.xfer(8'hff, n9, rx, ak);
		if (exp_ack)
			chk_byte(rx, model, "read data");
		sti_i2c_master_i.stop();
		repeat (16) @(posedge clk);
		chk_bit(sda_oe, 1'b0, "bus released");
	endtask

	task automatic t_regs();
		logic [6:0] bad_a[3] = '{7'h61, 7'h62, 7'h30};
		chk_cfg();
		wr(`STI_ADDR_A, 8'h06, 1'b1);
		rd(`STI_ADDR_A, 1'b1, 1'b1);
		wr(`STI_ADDR_A, 8'h87, 1'b1);
		rd(`STI_ADDR_A, 1'b0, 1'b1);
		foreach (bad_a[k]) begin
			wr(bad_a[k], 8'h02, 1'b0);
			rd(bad_a[k], 1'b1, 1'b0);
		end
		$display("register access test done");
	endtask

	// A START inside the commit window must go unanswered
	task automatic t_busy();
		logic [7:0] rx;
		logic       ak;
		sti_i2c_master_i.start(16);
		sti_i2c_master_i.xfer({`STI_ADDR_A, 1'b0}, 1'b1, rx, ak);
		sti_i2c_master_i.xfer(8'h00, 1'b1, rx, ak);
		sti_i2c_master_i.stop();
		sti_i2c_master_i.start(2);
		sti_i2c_master_i.xfer({`STI_ADDR_A, 1'b1}, 1'b1, rx, ak);
		chk_bit(ak, 1'b0, "request during commit");
		sti_i2c_master_i.xfer(8'hff, 1'b1, rx, ak);
		sti_i2c_master_i.stop();
		repeat (20) @(posedge clk);
		model = 8'h00;
		chk_cfg();
		$display("busy test done");
	endtask

	task automatic t_trip();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			therm <= (k == 0);
			ovc <= (k == 1);
			repeat (8) @(posedge clk);
			chk_bit(en, 1'b0, "trip turns regulator off");
			therm <= 1'b0;
			ovc <= 1'b0;
			repeat (8) @(posedge clk);
			chk_bit(en, 1'b1, "regulator back");
		end
		$display("protection test done");
	endtask

	// Paths run with the regulator off
	task automatic t_paths();
		wr(`STI_ADDR_A, 8'h80, 1'b1);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			hrst <= k[0];
			hclk <= k[1];
			repeat (5) @(posedge clk);
			chk_bit(crst, k[0], "reset path");
			chk_bit(cclk, k[1], "clock path");
		end
		$display("one-way path test done");
	endtask

	task automatic t_data();
		int k;
		@(posedge clk);
		host_low <= 1'b1;
		repeat (6) @(posedge clk);
		chk_bit(card_oe & ~card_o, 1'b1, "card follows host low");
		chk_bit(host_oe, 1'b0, "owner side not driven");
		host_low <= 1'b0;
		k = 0;
		while (!(card_oe === 1'b1 && card_o === 1'b1) && k < 10) begin
			@(posedge clk);
			k++;
		end
		chk_bit(card_oe & card_o, 1'b1, "rise kick on card");
		repeat (12) @(posedge clk);
		chk_bit(card_oe, 1'b0, "kick ends");
		card_low <= 1'b1;
		repeat (6) @(posedge clk);
		chk_bit(host_oe & ~host_o, 1'b1, "host follows card low");
		card_low <= 1'b0;
		k = 0;
		while (!(host_oe === 1'b1 && host_o === 1'b1) && k < 10) begin
			@(posedge clk);
			k++;
		end
		chk_bit(host_oe & host_o, 1'b1, "rise kick on host");
		repeat (12) @(posedge clk);
		chk_bit(host_oe, 1'b0, "host kick ends");
		host_low <= 1'b1;
		repeat (6) @(posedge clk);
		card_low <= 1'b1;
		repeat (6) @(posedge clk);
		host_low <= 1'b0;
		repeat (12) @(posedge clk);
		card_low <= 1'b0;
		repeat (20) @(posedge clk);
		chk_bit(host_w & card_w, 1'b1, "both sides high after clash");
		$display("data channel test done");
	endtask

	// A later supply drop is modelled by a second reset
	task automatic t_rereset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		model = 8'h00;
		chk_cfg();
		rd(`STI_ADDR_A, 1'b1, 1'b1);
		$display("second reset test done");
	endtask

	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{hrst, hclk, host_low, card_low, therm, ovc} = '0;
		model = 8'h00;
		bad_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		t_regs();
		t_busy();
		t_trip();
		t_paths();
		t_data();
		t_rereset();
		conclude();
	end

	// Watchdog well above the roughly 5600 cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		conclude();
	end
endmodule // sti_ctrl_tb
